// *** pc_stack_indirect.sv ***
// Function
// - Program counter is 13 bits and selects the fetched instruction.
// - PC low byte is a software readable and writable register.
// - PC bits 12..8 are hidden; a PC low byte write loads them all from the latch.
// - Call and jump carry 11 bits; page comes from latch bits 4..3.
// - Returns load the full stacked address, ignoring page bits.
// - A continuous 8K word program space is addressed.
// - Return stack holds eight 13-bit entries.
// - Stack lies outside memory maps; its pointer is not accessible.
// - Calls and interrupt branches push the program counter.
// - Plain return, literal return and interrupt return pop the stack.
// - Pushes and pops never touch the high address latch.
// - Stack wraps: ninth push overwrites the first, no overflow signal.
// - Indirect data port has no storage; it reaches the pointed register.
// - Indirect read with pointer zero returns 00h.
// - Indirect write with pointer zero changes no data.
// - Indirect address is bank bit above the 8-bit pointer.
`timescale 1ns/1ps
`default_nettype none

module pc_stack_indirect (
  // Clock and reset
  input  wire logic                              ref_clk_i,
  input  wire logic                              rst_i,
  // APB slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [pc_stack_pkg::APB_AW-1:0]   paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // Core instruction flow
  input  wire pc_stack_pkg::core_req_t           core_req_i,
  output logic      [pc_stack_pkg::PC_W-1:0]     fetch_addr_o,
  // Data memory behind the indirect port
  output pc_stack_pkg::dmem_req_t                dmem_req_o,
  input  wire logic [pc_stack_pkg::DATA_W-1:0]   dmem_rdata_i
);

  // ==========================================================
  // Declarations
  // ==========================================================
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_DONE  = 3'b100
  } ind_state_t;

  ind_state_t                        ind_state_reg;
  ind_state_t                        ind_state_next;

  logic [pc_stack_pkg::PC_W-1:0]     pc_reg;
  logic [pc_stack_pkg::PC_W-1:0]     pc_next;
  logic [4:0]                        pc_high_latch_reg;
  logic [pc_stack_pkg::DATA_W-1:0]   indirect_pointer_reg;
  logic                              indirect_bank_bit_reg;
  logic [31:0]                       prdata_reg;
  logic [31:0]                       prdata_next;
  logic                              slverr_reg;

  logic [pc_stack_pkg::PC_W-1:0]     stack_top;
  logic [pc_stack_pkg::PC_W-1:0]     push_addr;
  logic [pc_stack_pkg::PC_W-1:0]     branch_addr;
  logic                              do_push;
  logic                              do_pop;

  logic                              setup_ph;
  logic                              access_ph;
  logic                              hit_pc_low;
  logic                              hit_latch;
  logic                              hit_pointer;
  logic                              hit_status;
  logic                              hit_ind;
  logic                              hit_any;
  logic                              wr_access;
  logic                              ind_self;
  logic                              ind_read;
  logic [pc_stack_pkg::DADDR_W-1:0]  ind_addr;

  // ==========================================================
  // APB decode
  // ==========================================================
  assign setup_ph    = psel & ~penable;
  assign access_ph   = psel & penable;
  assign hit_pc_low  = (paddr == pc_stack_pkg::OFF_PC_LOW_BYTE);
  assign hit_latch   = (paddr == pc_stack_pkg::OFF_PC_HIGH_LATCH);
  assign hit_pointer = (paddr == pc_stack_pkg::OFF_IND_POINTER);
  assign hit_status  = (paddr == pc_stack_pkg::OFF_STATUS);
  assign hit_ind     = (paddr == pc_stack_pkg::OFF_IND_DATA_PORT);
  assign hit_any     = hit_pc_low | hit_latch | hit_pointer | hit_status | hit_ind;

  // Write takes effect only in the completing access cycle
  assign wr_access   = access_ph & pwrite & pready;

  // ==========================================================
  // Indirect addressing
  // ==========================================================
  assign ind_addr = {indirect_bank_bit_reg, indirect_pointer_reg};
  assign ind_self = (indirect_pointer_reg == 8'h00);
  assign ind_read = psel & ~pwrite & hit_ind & ~ind_self;

  // Memory read issued once per transfer, data back one cycle later
  always_comb begin
    dmem_req_o.rd    = setup_ph & ind_read;
    dmem_req_o.wr    = wr_access & hit_ind & ~ind_self;
    dmem_req_o.addr  = ind_addr;
    dmem_req_o.wdata = pwdata[pc_stack_pkg::DATA_W-1:0];
  end

  // Wait states for an indirect read only
  always_comb begin
    ind_state_next = ind_state_reg;
    unique case (ind_state_reg)
      ST_IDLE: begin
        if (setup_ph && ind_read) begin
          ind_state_next = ST_FETCH;
        end
      end
      ST_FETCH: begin
        ind_state_next = ST_DONE;
      end
      ST_DONE: begin
        ind_state_next = ST_IDLE;
      end
      default: begin
        ind_state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ind_state_reg <= ST_IDLE;
    end else begin
      ind_state_reg <= ind_state_next;
    end
  end

  // Zero wait for all but an indirect read
  assign pready = (ind_state_reg == ST_FETCH) ? 1'b0 : 1'b1;

  // ==========================================================
  // Read data
  // ==========================================================
  always_comb begin
    prdata_next = prdata_reg;
    if (ind_state_reg == ST_FETCH) begin
      prdata_next = {24'h000000, dmem_rdata_i};
    end else if (setup_ph && !pwrite) begin
      prdata_next = 32'h00000000;
      if (hit_pc_low) begin
        prdata_next[7:0] = pc_reg[7:0];
      end else if (hit_latch) begin
        prdata_next[4:0] = pc_high_latch_reg;
      end else if (hit_pointer) begin
        prdata_next[7:0] = indirect_pointer_reg;
      end else if (hit_status) begin
        prdata_next[pc_stack_pkg::BANK_BIT_POS] = indirect_bank_bit_reg;
      end else if (hit_ind && ind_self) begin
        prdata_next[7:0] = pc_stack_pkg::SELF_READ_VAL;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      prdata_reg <= 32'h00000000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  // Unmapped offsets answer with an error, no effect
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      slverr_reg <= 1'b0;
    end else if (setup_ph) begin
      slverr_reg <= ~hit_any;
    end
  end

  assign prdata  = prdata_reg;
  assign pslverr = access_ph & slverr_reg;

  // ==========================================================
  // Software registers
  // ==========================================================
  // Latch is written by software only; stack traffic leaves it alone
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pc_high_latch_reg <= pc_stack_pkg::LATCH_RST;
    end else if (wr_access && hit_latch) begin
      pc_high_latch_reg <= pwdata[pc_stack_pkg::LATCH_HI_BIT:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      indirect_pointer_reg <= pc_stack_pkg::POINTER_RST;
    end else if (wr_access && hit_pointer) begin
      indirect_pointer_reg <= pwdata[pc_stack_pkg::DATA_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      indirect_bank_bit_reg <= pc_stack_pkg::BANK_RST;
    end else if (wr_access && hit_status) begin
      indirect_bank_bit_reg <= pwdata[pc_stack_pkg::BANK_BIT_POS];
    end
  end

  // ==========================================================
  // Program flow
  // ==========================================================
  // Page bits come from the latch, offset from the instruction
  assign branch_addr = {pc_high_latch_reg[pc_stack_pkg::PAGE_HI_BIT:pc_stack_pkg::PAGE_LO_BIT],
                        core_req_i.target};

  // Interrupt saves the interrupted address, a call the next one
  assign push_addr = core_req_i.irq_branch ? pc_reg : pc_reg + 13'h0001;

  assign do_push = core_req_i.irq_branch | core_req_i.call;
  assign do_pop  = ~do_push & (core_req_i.ret_plain |
                               core_req_i.return_with_literal |
                               core_req_i.return_from_interrupt);

  always_comb begin
    pc_next = pc_reg;
    if (wr_access && hit_pc_low) begin
      // Computed jump: whole upper part follows the latch
      pc_next = {pc_high_latch_reg, pwdata[7:0]};
    end else if (core_req_i.irq_branch) begin
      pc_next = pc_stack_pkg::IRQ_VECTOR;
    end else if (core_req_i.call || core_req_i.jump_instruction) begin
      pc_next = branch_addr;
    end else if (do_pop) begin
      pc_next = stack_top;
    end else if (core_req_i.advance) begin
      pc_next = pc_reg + 13'h0001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pc_reg <= pc_stack_pkg::PC_RST;
    end else begin
      pc_reg <= pc_next;
    end
  end

  assign fetch_addr_o = pc_reg;

  // ==========================================================
  // Return stack
  // ==========================================================
  return_stack u_return_stack (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .push_i      (do_push),
    .pop_i       (do_pop),
    .push_addr_i (push_addr),
    .top_addr_o  (stack_top)
  );

endmodule : pc_stack_indirect

`default_nettype wire

// *** pc_stack_pkg.sv ***
package pc_stack_pkg;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int PC_W       = 13;
  localparam int TARGET_W   = 11;
  localparam int DATA_W     = 8;
  localparam int DADDR_W    = 9;
  localparam int STACK_W    = 3;
  localparam int STACK_D    = 8;
  localparam int APB_AW     = 8;

  // ==========================================================
  // Register byte offsets
  // ==========================================================
  localparam logic [APB_AW-1:0] OFF_PC_LOW_BYTE   = 8'h00;
  localparam logic [APB_AW-1:0] OFF_PC_HIGH_LATCH = 8'h04;
  localparam logic [APB_AW-1:0] OFF_IND_POINTER   = 8'h08;
  localparam logic [APB_AW-1:0] OFF_STATUS        = 8'h0c;
  localparam logic [APB_AW-1:0] OFF_IND_DATA_PORT = 8'h10;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int LATCH_HI_BIT   = 4;
  localparam int PAGE_HI_BIT    = 4;
  localparam int PAGE_LO_BIT    = 3;
  localparam int BANK_BIT_POS   = 7;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [PC_W-1:0]    PC_RST       = 13'h0000;
  localparam logic [4:0]         LATCH_RST    = 5'h00;
  localparam logic [DATA_W-1:0]  POINTER_RST  = 8'h00;
  localparam logic               BANK_RST     = 1'b0;
  localparam logic [STACK_W-1:0] STACK_PTR_RST = 3'h0;
  localparam logic [PC_W-1:0]    IRQ_VECTOR   = 13'h0004;
  localparam logic [DATA_W-1:0]  SELF_READ_VAL = 8'h00;

  // ==========================================================
  // Core instruction request
  // ==========================================================
  typedef struct packed {
    logic                advance;
    logic                call;
    logic                jump_instruction;
    logic                ret_plain;
    logic                return_with_literal;
    logic                return_from_interrupt;
    logic                irq_branch;
    logic [TARGET_W-1:0] target;
  } core_req_t;

  // Indirect data memory request
  typedef struct packed {
    logic               rd;
    logic               wr;
    logic [DADDR_W-1:0] addr;
    logic [DATA_W-1:0]  wdata;
  } dmem_req_t;

endpackage : pc_stack_pkg

// *** return_stack.sv ***
`timescale 1ns/1ps
`default_nettype none

module return_stack (
  // Clock and reset
  input  wire logic                          ref_clk_i,
  input  wire logic                          rst_i,
  // Push and pop
  input  wire logic                          push_i,
  input  wire logic                          pop_i,
  input  wire logic [pc_stack_pkg::PC_W-1:0] push_addr_i,
  output logic      [pc_stack_pkg::PC_W-1:0] top_addr_o
);

  // ==========================================================
  // Storage, hidden from program and data space
  // ==========================================================
  logic [pc_stack_pkg::PC_W-1:0]    entry_mem [pc_stack_pkg::STACK_D];
  logic [pc_stack_pkg::STACK_W-1:0] ptr_reg;
  logic [pc_stack_pkg::STACK_W-1:0] ptr_prev;

  assign ptr_prev   = ptr_reg - 3'h1;
  assign top_addr_o = entry_mem[ptr_prev];

  // Pointer wraps modulo eight, no overflow flag
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ptr_reg <= pc_stack_pkg::STACK_PTR_RST;
    end else if (push_i) begin
      ptr_reg <= ptr_reg + 3'h1;
    end else if (pop_i) begin
      ptr_reg <= ptr_prev;
    end
  end

  // Ninth push lands on the first entry
  always_ff @(posedge ref_clk_i) begin
    if (push_i) begin
      entry_mem[ptr_reg] <= push_addr_i;
    end
  end

endmodule : return_stack

`default_nettype wire

// *** pc_stack_indirect_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

module pc_stack_indirect_monitor (
  // Clock and reset
  input wire logic                            ref_clk_i,
  input wire logic                            rst_i,
  // APB
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic [pc_stack_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0]                     pwdata,
  input wire logic [31:0]                     prdata,
  input wire logic                            pready,
  input wire logic                            pslverr,
  // Core and data memory
  input wire pc_stack_pkg::core_req_t         core_req_i,
  input wire logic [12:0]                     fetch_addr_o,
  input wire pc_stack_pkg::dmem_req_t         dmem_req_o,
  input wire logic [7:0]                      dmem_rdata_i
);
  logic [4:0]  lat_reg;
  logic [7:0]  ptr_reg;
  logic        bank_reg;
  logic [12:0] br_reg;
  logic [12:0] pcw_reg;
  logic        done, pcw, brk, ret, idle;
  assign done = psel & penable & pready;
  assign idle = ~pcw & (core_req_i == '0);
  assign pcw  = done & pwrite & (paddr == pc_stack_pkg::OFF_PC_LOW_BYTE);
  assign brk  = ~pcw & ~core_req_i.irq_branch;
  assign ret  = brk & ~core_req_i.call & ~core_req_i.jump_instruction
              & (core_req_i.ret_plain | core_req_i.return_with_literal
                 | core_req_i.return_from_interrupt);

  // ==========================================================
  // Shadow of software state
  // ==========================================================
  always_ff @(posedge ref_clk_i) begin
    br_reg  <= {lat_reg[4:3], core_req_i.target};
    pcw_reg <= {lat_reg, pwdata[7:0]};
    if (rst_i) begin
      lat_reg  <= 5'h00;
      ptr_reg  <= 8'h00;
      bank_reg <= 1'b0;
    end else if (done & pwrite) begin
      if (paddr == pc_stack_pkg::OFF_PC_HIGH_LATCH) lat_reg <= pwdata[4:0];
      if (paddr == pc_stack_pkg::OFF_IND_POINTER) ptr_reg <= pwdata[7:0];
      if (paddr == pc_stack_pkg::OFF_STATUS) bank_reg <= pwdata[7];
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_branch_page: assert property (brk & (core_req_i.call | core_req_i.jump_instruction)
    |=> fetch_addr_o == br_reg) else $error("branch target page wrong");
  a_pc_write_load: assert property (pcw |=> fetch_addr_o == pcw_reg)
    else $error("pc low write did not load upper bits");
  a_irq_vector: assert property (~pcw & core_req_i.irq_branch
    |=> fetch_addr_o == pc_stack_pkg::IRQ_VECTOR) else $error("interrupt vector wrong");
  a_call_return_pair: assert property (brk & core_req_i.call ##1 idle ##1 ret
    |=> fetch_addr_o == $past(fetch_addr_o, 3) + 13'h1) else $error("return after call wrong");
  a_irq_return_pair: assert property (~pcw & core_req_i.irq_branch ##1 idle ##1 ret
    |=> fetch_addr_o == $past(fetch_addr_o, 3)) else $error("return after interrupt wrong");
  a_ind_address: assert property (dmem_req_o.rd | dmem_req_o.wr
    |-> dmem_req_o.addr == {bank_reg, ptr_reg}) else $error("indirect address wrong");
  a_self_write_block: assert property (dmem_req_o.wr |-> ptr_reg != 8'h00 && pwrite
    && paddr == pc_stack_pkg::OFF_IND_DATA_PORT) else $error("unexpected data write");
  a_self_read_zero: assert property (done & ~pwrite & ptr_reg == 8'h00
    & paddr == pc_stack_pkg::OFF_IND_DATA_PORT |-> prdata == 32'h0) else $error("self read");
  a_latch_readback: assert property (done & ~pwrite & paddr == pc_stack_pkg::OFF_PC_HIGH_LATCH
    |-> prdata == {27'h0, lat_reg}) else $error("latch readback wrong");
  a_ind_read_wait: assert property (psel & ~penable & ~pwrite & ptr_reg != 8'h00
    & paddr == pc_stack_pkg::OFF_IND_DATA_PORT |=> ~pready ##1 pready) else $error("read wait");

  c_pc_write: cover property (pcw);
  c_call_return: cover property (brk & core_req_i.call ##1 idle ##1 ret);
  c_irq_return: cover property (~pcw & core_req_i.irq_branch ##1 idle ##1 ret);
  c_ind_read: cover property (dmem_req_o.rd ##1 ~pready);
endmodule : pc_stack_indirect_monitor

bind pc_stack_indirect pc_stack_indirect_monitor u_pc_stack_indirect_monitor (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .core_req_i(core_req_i), .fetch_addr_o(fetch_addr_o), .dmem_req_o(dmem_req_o),
  .dmem_rdata_i(dmem_rdata_i));

`default_nettype wire

// *** pc_stack_indirect_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module pc_stack_indirect_test;
  logic ref_clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, se;
  logic [7:0]  paddr = 0, dmem_rdata_i = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [12:0] fetch_addr_o, exp_pc = 0;
  logic [12:0] stk [8];
  logic [7:0]  mem [512];
  logic [2:0]  sp = 0;
  logic [4:0]  lat = 0;
  int          err_count = 0, checked = 0, cycles = 0;
  pc_stack_pkg::core_req_t core_req_i = '0;
  pc_stack_pkg::dmem_req_t dmem_req_o;

  pc_stack_indirect u_pc_stack_indirect (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_req_i(core_req_i), .fetch_addr_o(fetch_addr_o), .dmem_req_o(dmem_req_o),
    .dmem_rdata_i(dmem_rdata_i));

  always #12.5 ref_clk_i = ~ref_clk_i;

  // ==========================================================
  // Synchronous data memory and timeout
  // ==========================================================
  always @(posedge ref_clk_i) begin
    if (dmem_req_o.wr) mem[dmem_req_o.addr] <= dmem_req_o.wdata;
    if (dmem_req_o.rd) dmem_rdata_i <= mem[dmem_req_o.addr];
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_count++;
      finish_test();
    end
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 1, {31'h0, pready});
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    if (w && a == pc_stack_pkg::OFF_PC_HIGH_LATCH) lat = d[4:0];
    if (w && a == pc_stack_pkg::OFF_PC_LOW_BYTE) exp_pc = {lat, d[7:0]};
    #1;
  endtask : apb

  // Kinds: 0 advance, 1 call, 2 jump, 3..5 returns, 6 interrupt
  task op(input int k, input logic [10:0] t);
    pc_stack_pkg::core_req_t r;
    r = '0;
    r.target = t;
    case (k)
      0: begin r.advance = 1; exp_pc++; end
      1: begin r.call = 1; stk[sp] = exp_pc + 1; sp++; exp_pc = {lat[4:3], t}; end
      2: begin r.jump_instruction = 1; exp_pc = {lat[4:3], t}; end
      6: begin r.irq_branch = 1; stk[sp] = exp_pc; sp++; exp_pc = pc_stack_pkg::IRQ_VECTOR; end
      default: begin
        r.ret_plain = (k == 3);
        r.return_with_literal = (k == 4);
        r.return_from_interrupt = (k == 5);
        sp--;
        exp_pc = stk[sp];
      end
    endcase
    @(posedge ref_clk_i);
    core_req_i <= r;
    @(posedge ref_clk_i);
    core_req_i <= '0;
    #1 chk("fetch_addr_o", {19'h0, exp_pc}, {19'h0, fetch_addr_o});
  endtask : op

  task finish_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  initial begin
    for (int i = 0; i < 512; i++) mem[i] = i[7:0] ^ 8'h5a;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 0;
    for (int i = 0; i < 5; i++) begin
      apb(0, 8'(i * 4), 0);
      chk("reset read", 0, rd);
    end
    apb(1, 8'h14, 32'h5a);
    chk("unmapped pslverr", 1, {31'h0, se});
    chk("reset pc", 0, {19'h0, fetch_addr_o});
    $display("test reset done");
    apb(1, pc_stack_pkg::OFF_PC_HIGH_LATCH, 32'hffff_ffff);
    apb(0, pc_stack_pkg::OFF_PC_HIGH_LATCH, 0);
    chk("latch", 32'h1f, rd);
    apb(1, pc_stack_pkg::OFF_PC_LOW_BYTE, 32'hab);
    chk("pc write", {19'h0, exp_pc}, {19'h0, fetch_addr_o});
    apb(0, pc_stack_pkg::OFF_PC_LOW_BYTE, 0);
    chk("pc low", 32'hab, rd);
    $display("test pc write done");
    for (int p = 0; p < 4; p++) begin
      apb(1, pc_stack_pkg::OFF_PC_HIGH_LATCH, p * 8);
      op(2, 11'h7ff);
      op(0, 0);
    end
    $display("test paging done");
    apb(1, pc_stack_pkg::OFF_PC_HIGH_LATCH, 0);
    op(2, 11'h100);
    for (int i = 0; i < 9; i++) op(1, 11'(32'h200 + i));
    apb(1, pc_stack_pkg::OFF_PC_HIGH_LATCH, 32'h18);
    for (int i = 0; i < 9; i++) op(3 + i % 3, 0);
    op(6, 0);
    op(5, 0);
    op(1, 11'h055);
    op(4, 0);
    apb(0, pc_stack_pkg::OFF_PC_HIGH_LATCH, 0);
    chk("latch kept", 32'h18, rd);
    $display("test stack done");
    apb(1, pc_stack_pkg::OFF_IND_POINTER, 32'h25);
    apb(1, pc_stack_pkg::OFF_STATUS, 32'hff);
    apb(0, pc_stack_pkg::OFF_STATUS, 0);
    chk("status", 32'h80, rd);
    apb(1, pc_stack_pkg::OFF_IND_DATA_PORT, 32'h3c);
    chk("banked write", 32'h3c, {24'h0, mem[9'h125]});
    apb(0, pc_stack_pkg::OFF_IND_DATA_PORT, 0);
    chk("banked read", 32'h3c, rd);
    apb(1, pc_stack_pkg::OFF_IND_POINTER, 0);
    apb(1, pc_stack_pkg::OFF_IND_DATA_PORT, 32'h77);
    chk("self write", 32'h5a, {24'h0, mem[9'h100]});
    apb(0, pc_stack_pkg::OFF_IND_DATA_PORT, 0);
    chk("self read", 0, rd);
    $display("test indirect done");
    finish_test();
  end
endmodule : pc_stack_indirect_test

`default_nettype wire
